// *** core/forc_pkg.sv ***
// forc_pkg: shared constants and types for the fifo offset/retransmit/reset control ends
// assumes both ends and the interface are compiled after this package
package forc_pkg;
  localparam int DATA_W         = 18;
  localparam int OFS_W          = 14;
  localparam int DEPTH_STD      = 16384;
  localparam int DEPTH_FALL_THROUGH_SELECT     = 16385;
  localparam int ADDR_W         = 14;
  // offset defaults selected at master reset
  localparam logic [13:0] OFS_DEF_PAR = 14'h007f;
  localparam logic [13:0] OFS_DEF_SER = 14'h03ff;
  // offset register pointer values
  localparam logic OPTR_EMPTY = 1'b0;
  localparam logic OPTR_FULL  = 1'b1;
  // flag valid delay, in edges of the flag's own clock
  localparam int FLAG_DLY = 2;
  // retransmit setup length in read clock edges
  localparam int RT_SETUP_CYC = 1;
  typedef enum logic [1:0] {FORC_RT_IDLE, FORC_RT_SETUP, FORC_RT_DONE} forc_rt_t;
endpackage

// *** core/forc_if.sv ***
// forc_if: pins between the fifo device and its hosts
// assumes hosts run on wr_clk and rd_clk, reset pins are asynchronous active low
`timescale 1ns/1ps
interface forc_if (
  input wire logic wr_clk,
  input wire logic rd_clk
);
  logic                          master_reset_n;
  logic                          partial_reset_n;
  logic                          fall_through_select;
  logic                          offset_load_n;
  logic                          write_enable_n;
  logic                          read_enable_n;
  logic                          retransmit_n;
  logic [forc_pkg::DATA_W-1:0]   input_bus;
  logic [forc_pkg::DATA_W-1:0]   output_bus;
  logic                          empty_flag_n;   // output_ready_n in fall-through mode
  logic                          full_flag_n;    // input_ready_n in fall-through mode
  logic                          half_full_flag_n;
  logic                          almost_empty_flag_n;
  logic                          almost_full_flag_n;
  logic                          almost_empty_valid;
  logic                          almost_full_valid;

  modport dev (
    input  wr_clk, rd_clk, master_reset_n, partial_reset_n, fall_through_select,
    input  offset_load_n, write_enable_n, read_enable_n, retransmit_n, input_bus,
    output output_bus, empty_flag_n, full_flag_n, half_full_flag_n,
    output almost_empty_flag_n, almost_full_flag_n, almost_empty_valid, almost_full_valid
  );
  modport host (
    input  wr_clk, rd_clk, output_bus, empty_flag_n, full_flag_n, half_full_flag_n,
    input  almost_empty_flag_n, almost_full_flag_n, almost_empty_valid, almost_full_valid,
    output master_reset_n, partial_reset_n, fall_through_select,
    output offset_load_n, write_enable_n, read_enable_n, retransmit_n, input_bus
  );
endinterface

// *** core/forc_dev.sv ***
// forc_dev: fifo end with offset registers, retransmit and reset control
// assumes host drives pins synchronous to wr_clk / rd_clk; resets asynchronous
`timescale 1ns/1ps
module forc_dev #(
  parameter int DATA_W = forc_pkg::DATA_W,
  parameter int DEPTH  = forc_pkg::DEPTH_STD
) (
  // pins toward the hosts
  forc_if.dev bus,
  // user side status
  output logic fall_through_mode,
  output logic parallel_method,
  output logic retransmit_busy
);
  localparam int AW = $clog2(DEPTH);
  // offsets must fit the bus and the pointers need a few words of room
  if (DATA_W < forc_pkg::OFS_W || DEPTH < 4) begin : g_bad_params
    $error("forc_dev: unsupported parameters");
  end

  // memory and pointers
  logic [DATA_W-1:0] mem [DEPTH];
  logic [AW-1:0]     wptr_r, rptr_r;
  logic [AW:0]       wcnt_r, rcnt_r;     // write word count since reset, read word count since reset or retransmit
  logic [forc_pkg::OFS_W-1:0] ofs_empty_r, ofs_full_r;
  logic              owptr_r, orptr_r;
  logic              ftm_r, par_r;
  logic [DATA_W-1:0] q_r;
  logic              ef_r, ff_r, hf_r, pae_r, paf_r;
  logic [1:0]        aev_sh_r, afv_sh_r;
  logic              af_prog_r;             // full offset just written
  forc_pkg::forc_rt_t rt_st_r;
  logic              fall_pend_r;
  logic              par_state_load;

  // reset qualifiers
  wire any_rst_n   = bus.master_reset_n & bus.partial_reset_n;
  wire mrs_n       = bus.master_reset_n;
  wire [AW:0] fill = wcnt_r - rcnt_r;
  wire full_now    = (fill >= (AW+1)'(DEPTH));
  wire empty_now   = (fill == '0);
  wire ofs_wr      = ~bus.offset_load_n & ~bus.write_enable_n & par_r;
  wire ofs_rd      = ~bus.offset_load_n & ~bus.read_enable_n;
  wire mem_wr      = bus.offset_load_n & ~bus.write_enable_n & ~full_now;
  wire rt_req      = ~bus.retransmit_n;
  wire mem_rd      = bus.offset_load_n & ~bus.read_enable_n & ~empty_now
                     & (rt_st_r != forc_pkg::FORC_RT_SETUP) & ~rt_req;
  wire [forc_pkg::OFS_W-1:0] ofs_rd_word = orptr_r ? ofs_full_r : ofs_empty_r;

  // mode and method captured while master reset is low
  always_ff @(posedge bus.wr_clk) begin
    if (!mrs_n) begin
      ftm_r <= bus.fall_through_select;
      par_r <= ~bus.offset_load_n;
    end
  end

  // write side: offsets and memory
  always_ff @(posedge bus.wr_clk or negedge mrs_n) begin
    if (!mrs_n) begin
      owptr_r     <= forc_pkg::OPTR_EMPTY;
      ofs_empty_r <= forc_pkg::OFS_DEF_SER;
      ofs_full_r  <= forc_pkg::OFS_DEF_SER;
      af_prog_r   <= 1'b0;
    end else if (par_state_load) begin
      ofs_empty_r <= par_r ? forc_pkg::OFS_DEF_PAR : forc_pkg::OFS_DEF_SER;
      ofs_full_r  <= par_r ? forc_pkg::OFS_DEF_PAR : forc_pkg::OFS_DEF_SER;
    end else if (ofs_wr) begin
      if (owptr_r == forc_pkg::OPTR_EMPTY) ofs_empty_r <= bus.input_bus[forc_pkg::OFS_W-1:0];
      else ofs_full_r <= bus.input_bus[forc_pkg::OFS_W-1:0];
      owptr_r   <= ~owptr_r;
      af_prog_r <= (owptr_r == forc_pkg::OPTR_FULL);
    end else begin
      af_prog_r <= 1'b0;
    end
  end
  // defaults land on first write clock after master reset release
  always_ff @(posedge bus.wr_clk or negedge mrs_n) begin
    if (!mrs_n) par_state_load <= 1'b1;
    else par_state_load <= 1'b0;
  end

  always_ff @(posedge bus.wr_clk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      wptr_r <= '0;
      wcnt_r <= '0;
    end else if (mem_wr) begin
      wptr_r      <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      wcnt_r      <= wcnt_r + 1'b1;
    end
  end

  // storage has no reset, so it sits in a process of its own
  always_ff @(posedge bus.wr_clk) begin
    if (mem_wr && any_rst_n) mem[wptr_r] <= bus.input_bus;
  end

  // almost full: valid two write edges after its offset lands
  always_ff @(posedge bus.wr_clk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      paf_r    <= 1'b1;
      ff_r     <= 1'b1;
      afv_sh_r <= '1;
    end else begin
      afv_sh_r <= {afv_sh_r[0], ~(ofs_wr & owptr_r == forc_pkg::OPTR_FULL) & afv_sh_r[0]
                   | af_prog_r};
      paf_r    <= ~(fill >= (AW+1)'(DEPTH) - (AW+1)'(ofs_full_r));
      ff_r     <= ~full_now;
    end
  end

  // read side: offset readback, memory reads, retransmit
  always_ff @(posedge bus.rd_clk or negedge mrs_n) begin
    if (!mrs_n) orptr_r <= forc_pkg::OPTR_EMPTY;
    else if (ofs_rd) orptr_r <= ~orptr_r;
  end

  always_ff @(posedge bus.rd_clk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      rptr_r      <= '0;
      rcnt_r      <= '0;
      q_r         <= '0;
      rt_st_r     <= forc_pkg::FORC_RT_IDLE;
      fall_pend_r <= 1'b0;
    end else begin
      case (rt_st_r)
        forc_pkg::FORC_RT_IDLE: begin
          if (rt_req) begin
            rptr_r  <= '0;
            rcnt_r  <= '0;
            rt_st_r <= forc_pkg::FORC_RT_SETUP;
          end else if (ofs_rd) begin
            q_r <= DATA_W'(ofs_rd_word);
          end else if (mem_rd) begin
            q_r    <= mem[rptr_r];
            rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
            rcnt_r <= rcnt_r + 1'b1;
          end
        end
        forc_pkg::FORC_RT_SETUP: begin
          rt_st_r <= forc_pkg::FORC_RT_DONE;
          if (ftm_r) begin
            q_r    <= mem[0];
            rptr_r <= AW'(1);
            rcnt_r <= (AW+1)'(1);
          end
        end
        forc_pkg::FORC_RT_DONE: rt_st_r <= forc_pkg::FORC_RT_IDLE;
        default: rt_st_r <= forc_pkg::FORC_RT_IDLE;
      endcase
    end
  end

  // read flags
  always_ff @(posedge bus.rd_clk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      ef_r     <= 1'b0;
      pae_r    <= 1'b0;
      aev_sh_r <= '1;
    end else begin
      // setup edge and the setup cycle show empty; done edge restores the flag
      ef_r     <= (rt_st_r != forc_pkg::FORC_RT_SETUP) & ~rt_req & ~empty_now;
      pae_r    <= (fill > (AW+1)'(ofs_empty_r));
      aev_sh_r <= {aev_sh_r[0], 1'b1};
    end
  end
  // half full updates on either clock; modelled combinationally from the counts
  always_comb hf_r = ~(fill > (AW+1)'(DEPTH/2));

  // outputs
  assign bus.output_bus          = q_r;
  assign bus.empty_flag_n        = ftm_r ? ~ef_r : ef_r;  // output ready is low when data stands
  assign bus.full_flag_n         = ftm_r ? ~ff_r : ff_r;
  assign bus.half_full_flag_n    = hf_r;
  assign bus.almost_empty_flag_n = pae_r;
  assign bus.almost_full_flag_n  = paf_r;
  assign bus.almost_empty_valid  = aev_sh_r[1];
  assign bus.almost_full_valid   = afv_sh_r[1];
  assign fall_through_mode       = ftm_r;
  assign parallel_method         = par_r;
  assign retransmit_busy         = (rt_st_r != forc_pkg::FORC_RT_IDLE);
endmodule

// *** core/forc_host.sv ***
// forc_host: host end driving the fifo pins from a plain user request port
// assumes wr_clk and rd_clk come from the interface; user ports sit on those clocks
`timescale 1ns/1ps
module forc_host #(
  parameter int DATA_W = forc_pkg::DATA_W
) (
  // pins toward the device
  forc_if.host bus,
  // reset and strap requests
  input  wire logic              rstn,
  input  wire logic              usr_partial_n,
  input  wire logic              usr_fall_through_select,
  input  wire logic              usr_parallel,
  // write side
  input  wire logic              usr_wr,
  input  wire logic              usr_ofs,
  input  wire logic [DATA_W-1:0] usr_wdata,
  // read side
  input  wire logic              usr_rd,
  input  wire logic              usr_rt,
  output logic [DATA_W-1:0]      usr_rdata
);
  logic rt_gate_r;

  // master reset follows rstn so no write precedes it
  assign bus.master_reset_n      = rstn;
  assign bus.partial_reset_n     = usr_partial_n;
  assign bus.fall_through_select = usr_fall_through_select;
  // offset loads never overlap reads and writes at once
  assign bus.offset_load_n       = rstn ? ~(usr_ofs & ~(usr_wr & usr_rd)) : ~usr_parallel;
  assign bus.write_enable_n      = ~usr_wr | usr_rt;
  assign bus.read_enable_n       = ~usr_rd | usr_rt;
  assign bus.input_bus           = usr_wdata;
  // retransmit one cycle after enables are high
  assign bus.retransmit_n        = ~(usr_rt & rt_gate_r);
  assign usr_rdata               = bus.output_bus;

  always_ff @(posedge bus.rd_clk or negedge rstn) begin
    if (!rstn) rt_gate_r <= 1'b0;
    else rt_gate_r <= usr_rt;
  end
endmodule

// *** sim/forc_assertions.sv ***
// forc_assertions: pin checks between the host and device ends
// assumes one clock feeds both sides; offsets are the low 14 bus bits
`timescale 1ns/1ps
module forc_assertions (
  // clocks and resets
  input wire logic        wr_clk,
  input wire logic        rd_clk,
  input wire logic        master_reset_n,
  input wire logic        partial_reset_n,
  // host controls
  input wire logic        fall_through_select,
  input wire logic        offset_load_n,
  input wire logic        write_enable_n,
  input wire logic        read_enable_n,
  input wire logic        retransmit_n,
  input wire logic [17:0] input_bus,
  // device answers
  input wire logic [17:0] output_bus,
  input wire logic        empty_flag_n,
  input wire logic        full_flag_n,
  input wire logic        half_full_flag_n,
  input wire logic        almost_empty_flag_n,
  input wire logic        almost_full_flag_n,
  input wire logic        almost_empty_valid,
  input wire logic        almost_full_valid
);
  logic [13:0] ofs_r [2];
  logic [13:0] exp_r;
  logic [17:0] fw_r;
  logic        par_r, ftm_r, wp_r, rp_r, got_r;
  // offset write, offset read and memory write decode
  wire         ow  = !offset_load_n && !write_enable_n && par_r;
  wire         orq = !offset_load_n && !read_enable_n;
  wire         mw  = offset_load_n && !write_enable_n && !got_r;
  wire [13:0]  dft = offset_load_n ? forc_pkg::OFS_DEF_SER : forc_pkg::OFS_DEF_PAR;
  // offset mirror; method and mode latch while master reset is low
  always_ff @(posedge wr_clk) begin
    if (!master_reset_n) begin
      par_r <= !offset_load_n;
      ftm_r <= fall_through_select;
      ofs_r[0] <= dft;
      ofs_r[1] <= dft;
    end else if (ow) begin
      ofs_r[wp_r] <= input_bus[13:0];
    end
  end
  // write pointer mirror
  always_ff @(posedge wr_clk or negedge master_reset_n) begin
    if (!master_reset_n) wp_r <= 1'b0;
    else if (ow) wp_r <= !wp_r;
  end
  // first memory word since any reset, for the fall-through replay
  always_ff @(posedge wr_clk or negedge master_reset_n) begin
    if (!master_reset_n) got_r <= 1'b0;
    else if (!partial_reset_n) got_r <= 1'b0;
    else if (mw) begin
      got_r <= 1'b1;
      fw_r <= input_bus;
    end
  end
  // read pointer survives partial reset
  always_ff @(posedge rd_clk or negedge master_reset_n) begin
    if (!master_reset_n) rp_r <= 1'b0;
    else if (orq) begin
      rp_r <= !rp_r;
      exp_r <= ofs_r[rp_r];
    end
  end
  default clocking dc @(posedge rd_clk); endclocking
  default disable iff (!master_reset_n);
  // master reset checks override the default disable so they can fire in reset
  AST_MRS_FLAGS: assert property (disable iff (1'b0)
    !master_reset_n && $past(!master_reset_n) |-> output_bus == 18'h0 && !almost_empty_flag_n
    && almost_full_flag_n && half_full_flag_n) else $error("master reset state wrong");
  AST_MRS_MODE: assert property (disable iff (1'b0)
    !master_reset_n && $past(!master_reset_n) |-> empty_flag_n == fall_through_select
    && full_flag_n != fall_through_select) else $error("mode flags wrong in reset");
  AST_PRS: assert property (!partial_reset_n && $past(!partial_reset_n) |->
    output_bus == 18'h0 && !almost_empty_flag_n && almost_full_flag_n
    && empty_flag_n == ftm_r) else $error("partial reset state wrong");
  AST_OFS_RD: assert property (orq |=> output_bus[13:0] == exp_r)
    else $error("offset readback wrong");
  AST_AE_VALID: assert property (ow && !wp_r |-> ##[2:3] almost_empty_valid)
    else $error("almost empty not valid");
  AST_AF_VALID: assert property (@(posedge wr_clk) ow && wp_r |-> ##[2:3] almost_full_valid)
    else $error("almost full not valid");
  AST_RT_STD: assert property (!ftm_r && $fell(retransmit_n) && read_enable_n
    && write_enable_n |=> !empty_flag_n ##[1:2] empty_flag_n) else $error("std retransmit");
  AST_RT_FT: assert property (ftm_r && $fell(retransmit_n) && read_enable_n
    && write_enable_n |=> empty_flag_n ##[1:2] (!empty_flag_n && output_bus == fw_r))
    else $error("fall-through retransmit");
  // main scenarios
  cover property (orq);
  cover property (ow && wp_r);
  cover property ($fell(retransmit_n));
endmodule

// *** sim/tb_fifo_offset_retransmit_reset_ctrl.sv ***
// tb_fifo_offset_retransmit_reset_ctrl: host and device ends joined by forc_if
// assumes usr_ofs marks offset traffic both ways, usr_parallel picks parallel
`timescale 1ns/1ps
module tb_fifo_offset_retransmit_reset_ctrl;
  logic        core_clk, rstn, usr_partial_n, usr_fall_through_select, usr_parallel;
  logic        usr_wr, usr_ofs, usr_rd, usr_rt, ftm, pm, rtb, psel;
  logic [17:0] usr_wdata, usr_rdata, first;
  logic [13:0] ofs [2];
  logic [31:0] seed;
  int          rp, wp, err_count, checks_done;
  forc_if ifc (.wr_clk(core_clk), .rd_clk(core_clk));
  // small depth keeps any fill short
  forc_dev #(.DEPTH(16)) forc_dev_i (.bus(ifc), .fall_through_mode(ftm),
    .parallel_method(pm), .retransmit_busy(rtb));
  forc_host forc_host_i (.bus(ifc), .rstn(rstn), .usr_partial_n(usr_partial_n),
    .usr_fall_through_select(usr_fall_through_select), .usr_parallel(usr_parallel), .usr_wr(usr_wr), .usr_ofs(usr_ofs),
    .usr_wdata(usr_wdata), .usr_rd(usr_rd), .usr_rt(usr_rt), .usr_rdata(usr_rdata));
  forc_assertions forc_assertions_i (.wr_clk(ifc.wr_clk), .rd_clk(ifc.rd_clk),
    .master_reset_n(ifc.master_reset_n), .partial_reset_n(ifc.partial_reset_n),
    .fall_through_select(ifc.fall_through_select), .offset_load_n(ifc.offset_load_n),
    .write_enable_n(ifc.write_enable_n), .read_enable_n(ifc.read_enable_n),
    .retransmit_n(ifc.retransmit_n), .input_bus(ifc.input_bus), .output_bus(ifc.output_bus),
    .empty_flag_n(ifc.empty_flag_n), .full_flag_n(ifc.full_flag_n),
    .half_full_flag_n(ifc.half_full_flag_n), .almost_empty_flag_n(ifc.almost_empty_flag_n),
    .almost_full_flag_n(ifc.almost_full_flag_n), .almost_empty_valid(ifc.almost_empty_valid),
    .almost_full_valid(ifc.almost_full_valid));
  // xorshift stimulus, fixed start
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [13:0] dflt(input logic par);
    return par ? forc_pkg::OFS_DEF_PAR : forc_pkg::OFS_DEF_SER;
  endfunction
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // master reset with straps held steady
  task automatic rst(input logic ft, input logic par);
    usr_fall_through_select <= ft;
    usr_parallel <= par;
    rstn <= 1'b0;
    tick(20);
    chk(ifc.output_bus, 18'h0);
    chk(18'(ifc.empty_flag_n), 18'(ft));
    rstn <= 1'b1;
    tick(4);
    chk(18'({ftm, pm}), 18'({ft, par}));
    ofs[0] = dflt(par);
    ofs[1] = dflt(par);
    rp = 0;
    wp = 0;
  endtask
  // one write, a gap after it pauses offset loading
  task automatic wr(input logic o, input logic [17:0] d);
    usr_wr <= 1'b1;
    usr_ofs <= o;
    usr_wdata <= d;
    tick(1);
    usr_wr <= 1'b0;
    usr_ofs <= 1'b0;
    tick(1);
    if (o && psel) begin
      ofs[wp] = d[13:0];
      wp ^= 1;
    end
  endtask
  task automatic rd(input logic o);
    usr_rd <= 1'b1;
    usr_ofs <= o;
    tick(1);
    usr_rd <= 1'b0;
    usr_ofs <= 1'b0;
    tick(4);
    if (o) begin
      chk({4'h0, usr_rdata[13:0]}, {4'h0, ofs[rp]});
      rp ^= 1;
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    {rstn, usr_fall_through_select, usr_wr, usr_ofs, usr_rd, usr_rt} = 6'h0;
    usr_partial_n = 1'b1;
    usr_parallel = 1'b1;
    usr_wdata = 18'h0;
    seed = 76;
    err_count = 0;
    checks_done = 0;
    // standard parallel, fall-through parallel, standard serial
    for (int m = 0; m < 3; m++) begin
      psel = (m != 2);
      rst(m[0], psel);
      repeat (3) rd(1'b1);
      wr(1'b1, 18'(xs()));
      wr(1'b0, 18'(xs()));
      repeat (2) wr(1'b1, 18'(xs()));
      repeat (3) rd(1'b1);
      usr_partial_n <= 1'b0;
      tick(4);
      chk(ifc.output_bus, 18'h0);
      usr_partial_n <= 1'b1;
      tick(4);
      rd(1'b1);
      first = 18'(xs());
      wr(1'b0, first);
      wr(1'b0, 18'(xs()));
      rd(1'b0);
      tick(3);
      // host gates retransmit one cycle behind the enables, so hold two cycles
      usr_rt <= 1'b1;
      tick(2);
      usr_rt <= 1'b0;
      tick(2);
      for (int k = 0; k < 20 && rtb !== 1'b0; k++) tick(1);
      if (rtb !== 1'b0) err_count++;
      tick(3);
      if (!m[0]) rd(1'b0);
      chk(usr_rdata, first);
      $display("test %0d done", m);
    end
    give_verdict();
  end
endmodule
